// ### core/hrs_status_gen.sv
// receive status byte generator for frames and characters
// assumes synchronous receiver strobes, at most one event per cycle
// and no new byte while rx_ready is low
//
// What this block does
// - in HDLC mode append an 8-bit status byte after each frame's data.
// - build the status byte when the receiver signals frame end.
// - valid flag clear for non-whole-byte frames, else set.
// - CRC-on minimum 4/6, 3/5, 3/5, 2/4 bytes by address and transparency.
// - CRC-off minimum 2 bytes for 16-bit address, else 1 byte.
// - frames below minimum produce neither data nor status byte.
// - overflow flag set on overflow; unmasked overflow raises an interrupt.
// - CRC flag is 1 on good check sequence, 0 on failure.
// - abort flag set on aborted frame; such frames still pass with their data and status.
// - compare high address with two programmed values and FE/FC.
// - high result 10 first, 00 second, 01 broadcast; equal gives 10.
// - copy command/response bit from high byte in 2-byte address mode.
// - low address compare: 1 for first match, 0 for second.
// - with store-status option, each character gets a status byte.
// - character framing-error bit is only meaningful in async mode.
`timescale 1ns/100ps
`default_nettype none
module hrs_status_gen (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // configuration
  input wire logic protocol_mode_sel_hi,
  input wire logic protocol_mode_sel_lo,
  input wire logic addr_width_select,
  input wire logic long_crc_select,
  input wire logic crc_check_disable,
  input wire logic char_mode_en,
  input wire logic char_async_sel,
  input wire logic store_status_with_char,
  input wire logic overflow_irq_mask,
  input wire logic [7:0] first_high_addr,
  input wire logic [7:0] second_high_addr,
  input wire logic [7:0] first_low_addr,
  input wire logic [7:0] second_low_addr,
  // receive side
  input wire logic rx_frame_start,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_frame_end,
  input wire logic rx_end_partial,
  input wire logic rx_end_abort,
  input wire logic rx_crc_ok,
  input wire logic rx_overflow,
  input wire logic char_framing_error,
  input wire logic char_parity_error,
  output logic rx_ready,
  // output stream
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_is_status,
  output logic out_last,
  output logic overflow_irq
);
  hrs_pkg::hrs_state_t state, next_state;
  logic [7:0] hold [hrs_pkg::HOLD_DEPTH];
  logic [7:0] next_hold [hrs_pkg::HOLD_DEPTH];
  logic [7:0] shifted [hrs_pkg::HOLD_DEPTH];
  logic [3:0] held, next_held;
  logic [3:0] cnt, next_cnt;
  logic ovf, next_ovf;
  logic [7:0] addr_hi, next_addr_hi;
  logic [7:0] addr_lo, next_addr_lo;
  logic [7:0] stat, next_stat;
  logic rdy, next_rdy;
  logic o_valid, next_o_valid;
  logic [7:0] o_data, next_o_data;
  logic o_stat, next_o_stat;
  logic o_last, next_o_last;
  logic irq, next_irq;
  logic [1:0] mode;
  logic transp, auto_mode;
  logic [3:0] min_len;
  logic [1:0] high_res;
  logic cmd_resp, low_match;

  assign mode = {protocol_mode_sel_hi, protocol_mode_sel_lo};
  assign transp = (mode == hrs_pkg::MODE_TRANSP);
  assign auto_mode = (mode == hrs_pkg::MODE_AUTO);

  // minimum length; addr_width_select picks transparent mode 1
  always_comb begin
    if (crc_check_disable) begin
      if (!transp && addr_width_select) begin
        min_len = hrs_pkg::MIN_NC_A16;
      end else begin
        min_len = hrs_pkg::MIN_NC_OTHER;
      end
    end else if (transp && !addr_width_select) begin
      min_len = long_crc_select ? hrs_pkg::MIN_T0_C32
                                : hrs_pkg::MIN_T0_CCITT;
    end else if (transp || !addr_width_select) begin
      min_len = long_crc_select ? hrs_pkg::MIN_A8_C32
                                : hrs_pkg::MIN_A8_CCITT;
    end else begin
      min_len = long_crc_select ? hrs_pkg::MIN_A16_C32
                                : hrs_pkg::MIN_A16_CCITT;
    end
  end

  hrs_addr_cmp u_addr (
    .hi_byte(addr_hi),
    .lo_byte(addr_lo),
    .auto_mode(auto_mode),
    .transp(transp),
    .addr16(addr_width_select),
    .first_high_addr(first_high_addr),
    .second_high_addr(second_high_addr),
    .first_low_addr(first_low_addr),
    .second_low_addr(second_low_addr),
    .high_res(high_res),
    .cmd_resp(cmd_resp),
    .low_match(low_match)
  );

  // hold line shifted by one entry toward the output
  genvar g;
  generate
    for (g = 0; g < hrs_pkg::HOLD_DEPTH; g = g + 1) begin : g_shift
      if (g == hrs_pkg::HOLD_DEPTH - 1) begin : g_top
        assign shifted[g] = 8'h00;
      end else begin : g_mid
        assign shifted[g] = hold[g + 1];
      end
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_hold = hold;
    next_held = held;
    next_cnt = cnt;
    next_ovf = ovf;
    next_addr_hi = addr_hi;
    next_addr_lo = addr_lo;
    next_stat = stat;
    next_rdy = rdy;
    next_o_valid = 1'b0;
    next_o_data = o_data;
    next_o_stat = 1'b0;
    next_o_last = 1'b0;
    next_irq = rx_overflow && !overflow_irq_mask;
    if (rx_overflow) begin
      next_ovf = 1'b1;
    end
    case (state)
      hrs_pkg::HRS_IDLE, hrs_pkg::HRS_RECV: begin
        if (char_mode_en) begin
          if (rx_byte_valid) begin
            next_o_valid = 1'b1;
            next_o_data = rx_byte;
            next_ovf = 1'b0;
            next_stat = 8'h00;
            next_stat[hrs_pkg::CBIT_FRM] = char_async_sel &&
                                           char_framing_error;
            next_stat[hrs_pkg::CBIT_PAR] = char_parity_error;
            next_stat[hrs_pkg::CBIT_OVF] = ovf || rx_overflow;
            if (store_status_with_char) begin
              next_state = hrs_pkg::HRS_STAT;
              next_rdy = 1'b0;
            end
          end
        end else if (rx_frame_start) begin
          // set wins: an overflow in the start cycle is kept
          next_ovf = rx_overflow;
          next_cnt = 4'h0;
          next_held = 4'h0;
          next_addr_hi = 8'h00;
          next_addr_lo = 8'h00;
          next_state = hrs_pkg::HRS_RECV;
        end else if (state == hrs_pkg::HRS_RECV && rx_byte_valid) begin
          if (cnt != hrs_pkg::CNT_MAX) begin
            next_cnt = cnt + hrs_pkg::CNT_ONE;
          end
          if (cnt == 4'h0) begin
            if (addr_width_select) begin
              next_addr_hi = rx_byte;
            end else begin
              next_addr_lo = rx_byte;
            end
          end else if (cnt == hrs_pkg::CNT_ONE && addr_width_select) begin
            next_addr_lo = rx_byte;
          end
          // bytes wait in the hold line until a new byte finds it full or the frame ends
          if (held == hrs_pkg::HOLD_FULL) begin
            next_o_valid = 1'b1;
            next_o_data = hold[0];
            next_hold = shifted;
            next_hold[hrs_pkg::HOLD_DEPTH - 1] = rx_byte;
          end else begin
            next_hold[held[2:0]] = rx_byte;
            next_held = held + hrs_pkg::CNT_ONE;
          end
        end else if (state == hrs_pkg::HRS_RECV && rx_frame_end) begin
          next_stat[hrs_pkg::BIT_VFR] = !rx_end_partial;
          next_stat[hrs_pkg::BIT_OVF] = ovf || rx_overflow;
          next_stat[hrs_pkg::BIT_CRC] = rx_crc_ok;
          next_stat[hrs_pkg::BIT_ABT] = rx_end_abort;
          next_stat[hrs_pkg::BIT_HAH] = high_res[1];
          next_stat[hrs_pkg::BIT_HAL] = high_res[0];
          next_stat[hrs_pkg::BIT_CR] = cmd_resp;
          next_stat[hrs_pkg::BIT_LA] = low_match;
          if (cnt < min_len) begin
            next_state = hrs_pkg::HRS_IDLE;
            next_held = 4'h0;
          end else begin
            next_state = hrs_pkg::HRS_DRAIN;
            next_rdy = 1'b0;
          end
        end
      end
      hrs_pkg::HRS_DRAIN: begin
        if (held == 4'h0) begin
          next_state = hrs_pkg::HRS_STAT;
        end else begin
          next_o_valid = 1'b1;
          next_o_data = hold[0];
          next_hold = shifted;
          next_held = held - hrs_pkg::CNT_ONE;
        end
      end
      hrs_pkg::HRS_STAT: begin
        next_o_valid = 1'b1;
        next_o_data = stat;
        next_o_stat = 1'b1;
        next_o_last = !char_mode_en;
        next_rdy = 1'b1;
        next_state = char_mode_en ? hrs_pkg::HRS_IDLE
                                  : hrs_pkg::HRS_IDLE;
      end
      default: begin
        next_state = hrs_pkg::HRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= hrs_pkg::HRS_IDLE;
      for (int i = 0; i < hrs_pkg::HOLD_DEPTH; i++) begin
        hold[i] <= 8'h00;
      end
      held <= 4'h0;
      cnt <= 4'h0;
      ovf <= 1'b0;
      addr_hi <= 8'h00;
      addr_lo <= 8'h00;
      stat <= 8'h00;
      rdy <= 1'b1;
      o_valid <= 1'b0;
      o_data <= 8'h00;
      o_stat <= 1'b0;
      o_last <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      hold <= next_hold;
      held <= next_held;
      cnt <= next_cnt;
      ovf <= next_ovf;
      addr_hi <= next_addr_hi;
      addr_lo <= next_addr_lo;
      stat <= next_stat;
      rdy <= next_rdy;
      o_valid <= next_o_valid;
      o_data <= next_o_data;
      o_stat <= next_o_stat;
      o_last <= next_o_last;
      irq <= next_irq;
    end
  end

  assign rx_ready = rdy;
  assign out_valid = o_valid;
  assign out_data = o_data;
  assign out_is_status = o_stat;
  assign out_last = o_last;
  assign overflow_irq = irq;
endmodule
`default_nettype wire

// ### include/hrs_pkg.sv
// constants for the receive status byte generator
// assumes one 200 MHz clock and an upstream serial receiver that
// delivers whole bytes with frame start and end marks
package hrs_pkg;
  // status byte bit positions
  localparam int unsigned BIT_VFR = 7;
  localparam int unsigned BIT_OVF = 6;
  localparam int unsigned BIT_CRC = 5;
  localparam int unsigned BIT_ABT = 4;
  localparam int unsigned BIT_HAH = 3;
  localparam int unsigned BIT_HAL = 2;
  localparam int unsigned BIT_CR = 1;
  localparam int unsigned BIT_LA = 0;
  // per-character status bit positions
  localparam int unsigned CBIT_FRM = 7;
  localparam int unsigned CBIT_PAR = 6;
  localparam int unsigned CBIT_OVF = 5;
  // position of the command/response bit in the high address byte
  localparam int unsigned CR_POS = 1;
  // protocol mode select {hi,lo}
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_NONAUTO = 2'h1;
  localparam logic [1:0] MODE_TRANSP = 2'h2;
  // broadcast high addresses
  localparam logic [7:0] BCAST_A = 8'hFE;
  localparam logic [7:0] BCAST_B = 8'hFC;
  // high address result codes
  localparam logic [1:0] HA_FIRST = 2'h2;
  localparam logic [1:0] HA_SECOND = 2'h0;
  localparam logic [1:0] HA_BCAST = 2'h1;
  localparam logic [1:0] HA_NONE = 2'h3;
  // minimum frame lengths in bytes
  localparam logic [3:0] MIN_A16_CCITT = 4'h4;
  localparam logic [3:0] MIN_A16_C32 = 4'h6;
  localparam logic [3:0] MIN_A8_CCITT = 4'h3;
  localparam logic [3:0] MIN_A8_C32 = 4'h5;
  localparam logic [3:0] MIN_T0_CCITT = 4'h2;
  localparam logic [3:0] MIN_T0_C32 = 4'h4;
  localparam logic [3:0] MIN_NC_A16 = 4'h2;
  localparam logic [3:0] MIN_NC_OTHER = 4'h1;
  // hold depth covers the largest minimum
  localparam int unsigned HOLD_DEPTH = 6;
  localparam logic [3:0] HOLD_FULL = 4'h6;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [3:0] CNT_ONE = 4'h1;
  typedef enum logic [1:0] {
    HRS_IDLE = 2'h0,
    HRS_RECV = 2'h1,
    HRS_DRAIN = 2'h3,
    HRS_STAT = 2'h2
  } hrs_state_t;
endpackage

// ### core/hrs_addr_cmp.sv
// address recognition for the frame status byte
// assumes the address bytes are held stable by the caller
`timescale 1ns/100ps
`default_nettype none
module hrs_addr_cmp (
  // received address bytes
  input wire logic [7:0] hi_byte,
  input wire logic [7:0] lo_byte,
  // mode
  input wire logic auto_mode,
  input wire logic transp,
  input wire logic addr16,
  // programmed addresses
  input wire logic [7:0] first_high_addr,
  input wire logic [7:0] second_high_addr,
  input wire logic [7:0] first_low_addr,
  input wire logic [7:0] second_low_addr,
  // results
  output logic [1:0] high_res,
  output logic cmd_resp,
  output logic low_match
);
  always_comb begin
    // first address checked first so equal programming reports 10
    high_res = hrs_pkg::HA_NONE;
    if (auto_mode && addr16) begin
      if (hi_byte == first_high_addr) begin
        high_res = hrs_pkg::HA_FIRST;
      end else if (hi_byte == second_high_addr) begin
        high_res = hrs_pkg::HA_SECOND;
      end else if (hi_byte == hrs_pkg::BCAST_A ||
                   hi_byte == hrs_pkg::BCAST_B) begin
        high_res = hrs_pkg::HA_BCAST;
      end
    end
    cmd_resp = 1'b0;
    if (addr16 && !transp) begin
      cmd_resp = hi_byte[hrs_pkg::CR_POS];
    end
    // no match on either low address also reads as 0
    low_match = 1'b0;
    if (!transp && lo_byte == first_low_addr) begin
      low_match = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### dv/hrs_checker.sv
// port-level assertions for the receive status byte generator
// bound into hrs_status_gen; sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module hrs_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // configuration and receive events
  input wire logic char_mode_en,
  input wire logic char_async_sel,
  input wire logic store_status_with_char,
  input wire logic overflow_irq_mask,
  input wire logic protocol_mode_sel_hi,
  input wire logic protocol_mode_sel_lo,
  input wire logic addr_width_select,
  input wire logic long_crc_select,
  input wire logic crc_check_disable,
  input wire logic rx_frame_start,
  input wire logic rx_byte_valid,
  input wire logic rx_frame_end,
  input wire logic rx_end_abort,
  input wire logic rx_crc_ok,
  input wire logic rx_overflow,
  input wire logic char_framing_error,
  // outputs
  input wire logic rx_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_is_status,
  input wire logic out_last,
  input wire logic overflow_irq
);
  logic in_frame, abt, crc, ovf, end_acc, chr_acc, byte_acc, t_mode, long_ok;
  logic next_in_frame, next_abt, next_crc, next_ovf;
  logic [3:0] nbytes, next_nbytes, min_len;
  assign t_mode = {protocol_mode_sel_hi, protocol_mode_sel_lo}
    == hrs_pkg::MODE_TRANSP;
  assign byte_acc = rx_ready && in_frame && rx_byte_valid && !rx_frame_start
    && !char_mode_en;
  assign end_acc = rx_ready && in_frame && rx_frame_end && !rx_frame_start
    && !rx_byte_valid && !char_mode_en;
  assign chr_acc = rx_ready && char_mode_en && rx_byte_valid
    && store_status_with_char;
  assign long_ok = nbytes >= min_len;
  // shortest frame that is still reported
  always_comb begin
    if (crc_check_disable) begin
      min_len = (addr_width_select && !t_mode) ? hrs_pkg::MIN_NC_A16
        : hrs_pkg::MIN_NC_OTHER;
    end else if (t_mode && !addr_width_select) begin
      min_len = long_crc_select ? hrs_pkg::MIN_T0_C32
        : hrs_pkg::MIN_T0_CCITT;
    end else if (t_mode || !addr_width_select) begin
      min_len = long_crc_select ? hrs_pkg::MIN_A8_C32
        : hrs_pkg::MIN_A8_CCITT;
    end else begin
      min_len = long_crc_select ? hrs_pkg::MIN_A16_C32
        : hrs_pkg::MIN_A16_CCITT;
    end
  end
  // per-frame copies of what the status byte must carry
  always_comb begin
    next_in_frame = in_frame;
    next_abt = abt;
    next_crc = crc;
    next_ovf = ovf | rx_overflow;
    next_nbytes = nbytes;
    if (rx_ready && rx_frame_start && !char_mode_en) begin
      next_in_frame = 1'b1;
      next_ovf = rx_overflow;
      next_nbytes = 4'h0;
    end else if (end_acc) begin
      next_in_frame = 1'b0;
      next_abt = rx_end_abort;
      next_crc = rx_crc_ok;
    end else if (byte_acc && nbytes != hrs_pkg::CNT_MAX) begin
      next_nbytes = nbytes + hrs_pkg::CNT_ONE;
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {in_frame, abt, crc, ovf} <= 4'h0;
      nbytes <= 4'h0;
    end else begin
      {in_frame, abt, crc, ovf} <= {next_in_frame, next_abt, next_crc,
        next_ovf};
      nbytes <= next_nbytes;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_irq_on_ovf: assert property (
    rx_overflow && !overflow_irq_mask |=> overflow_irq)
    else $error("overflow interrupt missing");
  a_irq_cause: assert property (
    overflow_irq |-> $past(rx_overflow) && !$past(overflow_irq_mask))
    else $error("overflow interrupt without cause");
  a_last_status: assert property (
    out_last |-> out_valid && out_is_status && !char_mode_en)
    else $error("frame status byte badly marked");
  a_end_ready: assert property (
    end_acc && long_ok |=> !rx_ready)
    else $error("ready not dropped after frame end");
  a_ready_back: assert property (
    end_acc |-> ##[2:14] rx_ready)
    else $error("ready not restored after frame end");
  a_short_drop: assert property (
    end_acc && !long_ok |=> (rx_ready && !out_valid) [*4])
    else $error("short frame was reported");
  a_last_abort: assert property (
    out_last |-> out_data[hrs_pkg::BIT_ABT] == abt)
    else $error("abort flag wrong");
  a_last_crc: assert property (
    out_last |-> out_data[hrs_pkg::BIT_CRC] == crc)
    else $error("crc flag wrong");
  a_last_ovf: assert property (
    out_last |-> out_data[hrs_pkg::BIT_OVF] == ovf)
    else $error("overflow flag wrong");
  a_char_pair: assert property (
    chr_acc |=> out_valid && !out_is_status ##1 out_valid && out_is_status)
    else $error("character not followed by status");
  a_char_fe: assert property (
    chr_acc && char_async_sel |-> ##2
    out_data[hrs_pkg::CBIT_FRM] == $past(char_framing_error, 2))
    else $error("character framing bit wrong");
  c_status: cover property (out_last && out_data[hrs_pkg::BIT_VFR]);
  c_char: cover property (chr_acc && char_async_sel);
  c_irq: cover property (overflow_irq);
  c_short: cover property (end_acc && !long_ok);
endmodule
bind hrs_status_gen hrs_checker chk_u (.mclk, .rst_b, .char_mode_en,
  .char_async_sel, .store_status_with_char, .overflow_irq_mask,
  .protocol_mode_sel_hi, .protocol_mode_sel_lo, .addr_width_select,
  .long_crc_select, .crc_check_disable,
  .rx_frame_start, .rx_byte_valid, .rx_frame_end, .rx_end_abort, .rx_crc_ok,
  .rx_overflow, .char_framing_error, .rx_ready, .out_valid, .out_data,
  .out_is_status, .out_last, .overflow_irq);
`default_nettype wire

// ### dv/hrs_station.sv
// remote station model driving the receive event lines
// events change at the falling edge; all but the idle event wait for rx_ready high
`timescale 1ns/100ps
`default_nettype none
module hrs_station (
  // clock and flow control
  input wire logic mclk,
  input wire logic rx_ready,
  // receive events
  output logic rx_frame_start,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_frame_end,
  output logic rx_end_partial,
  output logic rx_end_abort,
  output logic rx_crc_ok,
  output logic rx_overflow,
  output logic char_framing_error,
  output logic char_parity_error
);
  initial begin
    {rx_frame_start, rx_byte_valid, rx_frame_end, rx_overflow} = 4'h0;
    {rx_end_partial, rx_end_abort, rx_crc_ok} = 3'h0;
    {char_framing_error, char_parity_error} = 2'h0;
    rx_byte = 8'h00;
  end
  // k: start, byte, end, overflow; idle lines show inverted leftovers
  task automatic ev(input logic [3:0] k, input logic [7:0] b,
                    input logic [2:0] q);
    @(negedge mclk);
    while (!rx_ready && k != 4'h0) @(negedge mclk);
    {rx_frame_start, rx_byte_valid, rx_frame_end, rx_overflow} = k;
    rx_byte = k[2] ? b : ~rx_byte;
    {rx_end_partial, rx_end_abort, rx_crc_ok} = k[1] ? q :
      ~{rx_end_partial, rx_end_abort, rx_crc_ok};
    {char_framing_error, char_parity_error} = k[2] ? q[1:0] :
      ~{char_framing_error, char_parity_error};
  endtask
endmodule
`default_nettype wire

// ### dv/hrs_status_gen_tb_top.sv
// self-checking bench for the receive status byte generator
// random frames and characters from a fixed seed, expectations computed here
`timescale 1ns/100ps
`default_nettype none
module hrs_status_gen_tb_top;
  logic mclk, rst_b, a16, c32, crcoff, chr, asy, sts, msk, rx_ready;
  logic out_valid, out_is_status, out_last, overflow_irq, rx_frame_start;
  logic rx_byte_valid, rx_frame_end, rx_end_partial, rx_end_abort, rx_crc_ok;
  logic rx_overflow, char_framing_error, char_parity_error;
  logic [7:0] rx_byte, out_data, fha, sha, fla, sla;
  logic [1:0] mode;
  integer seed;
  int num_errors, n_checks, it;
  logic [9:0] got[$];
  hrs_status_gen dut_u (.mclk, .rst_b, .protocol_mode_sel_hi(mode[1]),
    .protocol_mode_sel_lo(mode[0]), .addr_width_select(a16),
    .long_crc_select(c32), .crc_check_disable(crcoff), .char_mode_en(chr),
    .char_async_sel(asy), .store_status_with_char(sts),
    .overflow_irq_mask(msk), .first_high_addr(fha), .second_high_addr(sha),
    .first_low_addr(fla), .second_low_addr(sla), .rx_frame_start,
    .rx_byte_valid, .rx_byte, .rx_frame_end, .rx_end_partial, .rx_end_abort,
    .rx_crc_ok, .rx_overflow, .char_framing_error, .char_parity_error,
    .rx_ready, .out_valid, .out_data, .out_is_status, .out_last,
    .overflow_irq);
  hrs_station st_u (.mclk, .rx_ready, .rx_frame_start, .rx_byte_valid,
    .rx_byte, .rx_frame_end, .rx_end_partial, .rx_end_abort, .rx_crc_ok,
    .rx_overflow, .char_framing_error, .char_parity_error);
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (out_valid === 1'b1)
    got.push_back({out_is_status, out_last, out_data});
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [3:0] min_len();
    logic t;
    t = mode == hrs_pkg::MODE_TRANSP;
    if (crcoff) return (a16 && !t) ? 4'h2 : 4'h1;
    return (t ? 4'h2 : 4'h3) + (a16 ? 4'h1 : 4'h0)
      + (c32 ? 4'h2 : 4'h0);
  endfunction
  function automatic logic [1:0] hres(input logic [7:0] h);
    if (h == fha) return hrs_pkg::HA_FIRST;
    if (h == sha) return hrs_pkg::HA_SECOND;
    if (h == 8'hFE || h == 8'hFC) return hrs_pkg::HA_BCAST;
    return hrs_pkg::HA_NONE;
  endfunction
  // address bytes often hit the programmed or broadcast values
  function automatic logic [7:0] pick(input int i);
    logic [7:0] r;
    r = $random(seed);
    if (i == 0 && r[7])
      return r[1] ? (r[0] ? fha : sha) : (r[0] ? 8'hFE : 8'hFC);
    if (i == (a16 ? 1 : 0) && r[6]) return r[0] ? fla : sla;
    return $random(seed);
  endfunction
  task automatic settle();
    int k;
    repeat (2) @(negedge mclk);
    for (k = 0; k < 40 && rx_ready !== 1'b1; k++) @(negedge mclk);
    repeat (2) @(negedge mclk);
  endtask
  task automatic frame(input int n, input logic [2:0] q, input logic o);
    logic [7:0] d[$];
    logic [7:0] s;
    logic t;
    t = mode == hrs_pkg::MODE_TRANSP;
    got.delete();
    st_u.ev(4'h8, 8'h00, 3'h0);
    for (int i = 0; i < n; i++) begin
      d.push_back(pick(i));
      st_u.ev(4'h4, d[i], 3'h0);
      if (o && i == 0) st_u.ev(4'h1, 8'h00, 3'h0);
    end
    st_u.ev(4'h2, 8'h00, q);
    st_u.ev(4'h0, 8'h00, 3'h0);
    settle();
    if (n < int'(min_len())) begin
      check(10'(got.size()), 10'h000);
      return;
    end
    check(10'(got.size()), 10'(n + 1));
    for (int i = 0; i < n; i++) check(got[i], {2'b00, d[i]});
    s[7] = !q[2];
    s[6] = o;
    s[5] = q[0];
    s[4] = q[1];
    s[3:2] = (mode == hrs_pkg::MODE_AUTO && a16) ? hres(d[0])
      : hrs_pkg::HA_NONE;
    s[1] = (a16 && !t) ? d[0][hrs_pkg::CR_POS] : 1'b0;
    s[0] = !t && d[a16 ? 1 : 0] == fla;
    check(got[n], {2'b11, s});
  endtask
  task automatic chr_byte(input logic [1:0] q);
    logic [7:0] b;
    logic [3:0] cs;
    b = $random(seed);
    got.delete();
    st_u.ev(4'h4, b, {1'b0, q});
    st_u.ev(4'h0, 8'h00, 3'h0);
    repeat (4) @(negedge mclk);
    check(10'(got.size()), sts ? 10'h002 : 10'h001);
    check(got[0], {2'b00, b});
    if (sts) begin
      cs = {got[1][9:8], got[1][7] & asy, got[1][6]};
      check(10'(cs), 10'({2'b10, q[1] & asy, q[0]}));
    end
  endtask
  initial begin
    logic [31:0] r;
    seed = 32'h87A03A5B;
    {mclk, rst_b, a16, c32, crcoff, chr, asy, sts, msk} = 9'h000;
    mode = hrs_pkg::MODE_AUTO;
    {fha, sha, fla, sla} = 32'h0102_0304;
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    for (it = 0; it < 300; it++) begin
      r = $random(seed);
      // code 11 must behave as non-auto
      mode = r[0] ? hrs_pkg::MODE_AUTO
        : (r[1] ? hrs_pkg::MODE_TRANSP : {r[7], 1'b1});
      {a16, c32, crcoff, msk} = r[5:2];
      fha = $random(seed);
      sha = r[6] ? fha : 8'($random(seed));
      fla = $random(seed);
      sla = ~fla;
      frame(int'(min_len()) - 1 + int'(r[9:8]), r[12:10], r[13]);
    end
    // reset in mid-frame, then a frame with an overflow must report alone
    st_u.ev(4'h8, 8'h00, 3'h0);
    st_u.ev(4'h4, 8'hA5, 3'h0);
    rst_b = 1'b0;
    st_u.ev(4'h0, 8'h00, 3'h0);
    r = 32'({rx_ready, out_valid, out_is_status, out_last, overflow_irq});
    check(r[9:0], 10'h010);
    rst_b = 1'b1;
    @(negedge mclk);
    r = 32'({rx_ready, out_valid, out_is_status, out_last, overflow_irq});
    check(r[9:0], 10'h010);
    frame(int'(min_len()) + 1, 3'h1, 1'b1);
    chr = 1'b1;
    for (it = 0; it < 16; it++) begin
      r = $random(seed);
      {asy, sts} = 2'(it);
      chr_byte(r[1:0]);
    end
    end_sim();
  end
  initial begin
    #100us;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
